// [src/fswps_regs.sv]
`timescale 1ns/1ps
`include "fswps_consts.svh"

module fswps_regs
  import fswps_pkg::*;
#(
  parameter int PHASES = 8
) (
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic enable_pin, // Controller enable pin
  input wire logic [3:0] resistor_code_in, // Digitised frequency resistor code
  input wire logic psl_mid_in, // Power-saving input at middle level
  input wire logic psl_low_in, // Power-saving input at low level
  input wire logic [PHASES-1:0] phase_en_in, // Phase enabled levels
  input wire fswps_req_t req, // Register access request, sampled only while req_valid is high
  input wire logic req_valid, // Access strobe
  output logic [7:0] rdata, // Read data, valid cycle after strobe
  output logic [4:0] freq_code, // Effective frequency code to the modulator
  output logic [7:0] second_func_mask // Bits set in both select registers
);

  // Elaboration-time refusal of phase counts the status bit map cannot serve
  if (PHASES != 8) begin : g_phase_check
    $error("fswps_regs serves exactly eight phases");
  end

  logic rst_s0_ff;
  logic rst_s1_ff;
  fswps_state_t st_ff;
  fswps_state_t nxt_st;
  logic en_rise;
  logic en_fall;
  logic [7:0] both_sel;
  logic [7:0] sf_mask_ff;
  logic [7:0] nxt_sf_mask;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s0_ff <= 1'b0;
      rst_s1_ff <= 1'b0;
    end else begin
      rst_s0_ff <= 1'b1;
      rst_s1_ff <= rst_s0_ff;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // en_sync[1] is the synchronised level; en_sync[2] its delayed copy
  assign en_rise = st_ff.en_sync[1] & ~st_ff.en_sync[2];
  assign en_fall = ~st_ff.en_sync[1] & st_ff.en_sync[2];
  assign both_sel = st_ff.second_a & st_ff.second_b;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.en_sync = {st_ff.en_sync[1:0], enable_pin};
    nxt_st.psl_sync0 = {psl_low_in, psl_mid_in};
    nxt_st.psl_sync1 = st_ff.psl_sync0;
    nxt_st.ph_sync0 = phase_en_in;
    nxt_st.ph_sync1 = st_ff.ph_sync0;
    case (st_ff.meas)
      FSWPS_IDLE: begin
        if (en_rise) begin
          nxt_st.meas = FSWPS_MEASURE;
        end
      end
      FSWPS_MEASURE: begin
        // Resistor code settles one cycle after the enable edge is seen
        nxt_st.status_code = resistor_code_in;
        nxt_st.meas = FSWPS_IDLE;
      end
      default: nxt_st.meas = FSWPS_IDLE;
    endcase
    if (en_rise || en_fall) begin
      nxt_st.second_a = 8'h00;
      nxt_st.second_b = 8'h00;
    end else if (req_valid && req.wr) begin
      case (req.addr)
        `FSWPS_OFS_FREQ_OVERRIDE: nxt_st.override_code = req.wdata[4:0];
        `FSWPS_OFS_SECOND_FUNC_A: nxt_st.second_a = req.wdata;
        `FSWPS_OFS_SECOND_FUNC_B: nxt_st.second_b = req.wdata;
        default: nxt_st.meas = nxt_st.meas;
      endcase
    end
    if (both_sel[`FSWPS_SECOND_FREQ_BIT]) begin
      nxt_st.freq_code = st_ff.override_code;
    end else begin
      nxt_st.freq_code = {st_ff.status_code, 1'b0};
    end
    // Pin sensing gives mid/low flags; neither set means high
    if (st_ff.psl_sync1[0]) begin
      nxt_st.psl_code = `FSWPS_PSL_MIDDLE;
    end else if (st_ff.psl_sync1[1]) begin
      nxt_st.psl_code = `FSWPS_PSL_LOW;
    end else begin
      nxt_st.psl_code = `FSWPS_PSL_HIGH;
    end
    nxt_st.rdata = 8'h00;
    if (req_valid && !req.wr) begin
      case (req.addr)
        `FSWPS_OFS_FREQ_STATUS: nxt_st.rdata = {4'h0, st_ff.status_code};
        `FSWPS_OFS_FREQ_OVERRIDE: nxt_st.rdata = {3'h0, st_ff.override_code};
        `FSWPS_OFS_PSL_STATUS: nxt_st.rdata = {6'h00, st_ff.psl_code};
        `FSWPS_OFS_PHASE_STATUS: nxt_st.rdata = st_ff.ph_sync1;
        `FSWPS_OFS_SECOND_FUNC_A: nxt_st.rdata = st_ff.second_a;
        `FSWPS_OFS_SECOND_FUNC_B: nxt_st.rdata = st_ff.second_b;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    nxt_sf_mask = both_sel;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_s1_ff) begin
    if (!rst_s1_ff) begin
      st_ff <= '0;
      sf_mask_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      sf_mask_ff <= nxt_sf_mask;
    end
  end

  assign rdata = st_ff.rdata;
  assign freq_code = st_ff.freq_code;
  assign second_func_mask = sf_mask_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_en_edge;
    st_ff.en_sync[1] && !st_ff.en_sync[2];
  endsequence

  a_status_on_edge: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    s_en_edge ##1 1'b1 |=> st_ff.status_code == $past(resistor_code_in))
    else $error("status code not captured after enable edge");

  a_status_stable: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (st_ff.meas == FSWPS_IDLE) |=> $stable(st_ff.status_code))
    else $error("status code changed without enable edge");

  a_override_select: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (st_ff.second_a[5] && st_ff.second_b[5]) |=> freq_code == $past(st_ff.override_code))
    else $error("override not applied");

  a_override_width: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (req_valid && !req.wr && req.addr == `FSWPS_OFS_FREQ_OVERRIDE) |=> rdata[7:5] == 3'h0)
    else $error("override reserved bits nonzero");

  a_resistor_map: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    !(st_ff.second_a[5] && st_ff.second_b[5]) |=> freq_code == {$past(st_ff.status_code), 1'b0})
    else $error("resistor code mapping wrong");

  a_psl_status: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    st_ff.psl_sync1 == 2'h0 |=> st_ff.psl_code == `FSWPS_PSL_HIGH)
    else $error("power-saving high level not reported");

  a_phase_read: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (req_valid && !req.wr && req.addr == `FSWPS_OFS_PHASE_STATUS) |=> rdata == $past(st_ff.ph_sync1))
    else $error("phase status read wrong");

  a_toggle_clears: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (en_rise || en_fall) |=> (st_ff.second_a == 8'h00 && st_ff.second_b == 8'h00))
    else $error("selects not cleared on enable toggle");

  a_status_ro: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (req_valid && req.wr && req.addr == `FSWPS_OFS_FREQ_STATUS && st_ff.meas == FSWPS_IDLE)
    |=> $stable(st_ff.status_code))
    else $error("status register took a write");

  a_measure_single: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (st_ff.meas == FSWPS_MEASURE) |=> (st_ff.meas == FSWPS_IDLE))
    else $error("measurement lasted more than one cycle");

  a_override_write: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (req_valid && req.wr && req.addr == `FSWPS_OFS_FREQ_OVERRIDE && !en_rise && !en_fall)
    |=> ({3'h0, st_ff.override_code} == ($past(req.wdata) & 8'h1F)))
    else $error("override write not stored in low five bits");

  a_status_read: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (req_valid && !req.wr && req.addr == `FSWPS_OFS_FREQ_STATUS) |=> rdata == {4'h0, $past(st_ff.status_code)})
    else $error("frequency status read wrong");

  a_psl_middle: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    st_ff.psl_sync1[0] |=> st_ff.psl_code == `FSWPS_PSL_MIDDLE)
    else $error("power-saving middle level not reported");

  a_psl_low: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    st_ff.psl_sync1 == 2'h2 |=> st_ff.psl_code == `FSWPS_PSL_LOW)
    else $error("power-saving low level not reported");

  a_psl_reserved: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    (req_valid && !req.wr && req.addr == `FSWPS_OFS_PSL_STATUS) |=> rdata[7:2] == 6'h00)
    else $error("power-saving reserved bits nonzero");

  a_mask_both: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    1'b1 |=> second_func_mask == $past(both_sel))
    else $error("select mask is not the AND of both selects");

  a_rdata_quiet: assert property (@(posedge clk_sys) disable iff (!rst_s1_ff)
    !(req_valid && !req.wr) |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

endmodule

// [src/fswps_consts.svh]
`ifndef FSWPS_CONSTS_SVH
`define FSWPS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FSWPS_OFS_FREQ_STATUS 8'h2F
`define FSWPS_OFS_FREQ_OVERRIDE 8'h30
`define FSWPS_OFS_PSL_STATUS 8'h32
`define FSWPS_OFS_PHASE_STATUS 8'h33
`define FSWPS_OFS_SECOND_FUNC_A 8'h46
`define FSWPS_OFS_SECOND_FUNC_B 8'h47

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define FSWPS_SECOND_FREQ_BIT 5
`define FSWPS_PSL_MIDDLE 2'h0
`define FSWPS_PSL_LOW 2'h1
`define FSWPS_PSL_HIGH 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSWPS_RST_OVERRIDE 5'h00
`define FSWPS_RST_STATUS 4'h0

`endif

// [src/fswps_pkg.sv]
package fswps_pkg;

  typedef enum logic [1:0] {
    FSWPS_IDLE,
    FSWPS_MEASURE
  } fswps_meas_t;

  // Register access request from the protocol engine
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fswps_req_t;

  typedef struct packed {
    logic [2:0] en_sync;
    logic [1:0] psl_sync0;
    logic [1:0] psl_sync1;
    logic [7:0] ph_sync0;
    logic [7:0] ph_sync1;
    fswps_meas_t meas;
    logic [3:0] status_code;
    logic [4:0] override_code;
    logic [7:0] second_a;
    logic [7:0] second_b;
    logic [4:0] freq_code;
    logic [1:0] psl_code;
    logic [7:0] rdata;
  } fswps_state_t;

endpackage

// [testbench/fswps_host_model.sv]
`timescale 1ns/1ps
`include "fswps_consts.svh"
module fswps_host_model
  import fswps_pkg::*;
(
  input wire logic clk_sys, // System clock
  output fswps_req_t req, // Access request
  output logic req_valid, // Access strobe
  input wire logic [7:0] rdata // Read data
);
  initial begin
    req = '0;
    req_valid = 1'b0;
  end
  // Strobe spans one edge; the answer stands the cycle after it
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    @(negedge clk_sys);
    req = '{wr: wr, addr: addr, wdata: wd};
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    // Released lines show the inverted request, never the last value
    req = ~req;
    rd = rdata;
  endtask
  // Either order must work, so the caller picks which select goes first
  task automatic write_selects(input logic [7:0] val, input logic b_first);
    logic [7:0] rd;
    access(1'b1, b_first ? `FSWPS_OFS_SECOND_FUNC_B : `FSWPS_OFS_SECOND_FUNC_A, val, rd);
    access(1'b1, b_first ? `FSWPS_OFS_SECOND_FUNC_A : `FSWPS_OFS_SECOND_FUNC_B, val, rd);
  endtask
endmodule

// [testbench/fswps_regs_tb_top.sv]
`timescale 1ns/1ps
`include "fswps_consts.svh"
module fswps_regs_tb_top
  import fswps_pkg::*;
();
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic [3:0] res = 4'h0;
  logic mid = 1'b1;
  logic low = 1'b0;
  logic [7:0] ph = 8'h00;
  fswps_req_t req;
  logic req_valid;
  logic [7:0] rdata, rd, wv, msk;
  logic [4:0] fc;
  int bad_count = 0;
  int n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  fswps_regs #(.PHASES(8)) i_dut(.clk_sys(clk_sys), .rst_n(rst_n), .enable_pin(en), .resistor_code_in(res),
    .psl_mid_in(mid), .psl_low_in(low), .phase_en_in(ph), .req(req), .req_valid(req_valid), .rdata(rdata),
    .freq_code(fc), .second_func_mask(msk));
  fswps_host_model i_host(.clk_sys(clk_sys), .req(req), .req_valid(req_valid), .rdata(rdata));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] fexp(input logic [3:0] r);
    return {3'h0, r, 1'b0};
  endfunction
  function automatic logic [7:0] pexp(input logic m, input logic l);
    return {6'h00, m ? `FSWPS_PSL_MIDDLE : l ? `FSWPS_PSL_LOW : `FSWPS_PSL_HIGH};
  endfunction
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    i_host.access(1'b0, a, 8'h00, rd);
    check(what, rd, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.access(1'b1, a, d, rd);
  endtask
  task automatic pin(input logic lvl);
    @(negedge clk_sys);
    en = lvl;
    repeat (10) @(negedge clk_sys);
  endtask
  // Watchdog: a hang ends the run as a failure
  initial begin
    #5ms;
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(32'h3B01));
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdc("status reset", 8'h2F, 8'h00);
    for (int k = 0; k < 4; k++) begin
      res = (k == 0) ? 4'hF : 4'($urandom);
      wv = (k == 1) ? 8'hFF : 8'($urandom);
      pin(1'b1);
      rdc("freq status", 8'h2F, {4'h0, res});
      check("freq code", {3'h0, fc}, fexp(res));
      res = ~res;
      repeat (8) @(negedge clk_sys);
      rdc("status held", 8'h2F, {4'h0, ~res});
      wr(8'h30, wv);
      rdc("override", 8'h30, {3'h0, wv[4:0]});
      wr(`FSWPS_OFS_SECOND_FUNC_A, 8'h20);
      repeat (2) @(negedge clk_sys);
      check("one select", {3'h0, fc}, fexp(~res));
      i_host.write_selects(8'h20, k[0]);
      repeat (2) @(negedge clk_sys);
      check("mask", msk, 8'h20);
      check("override code", {3'h0, fc}, {3'h0, wv[4:0]});
      rdc("select b", `FSWPS_OFS_SECOND_FUNC_B, 8'h20);
      wr(8'h30, ~wv);
      repeat (2) @(negedge clk_sys);
      check("override live", {3'h0, fc}, {3'h0, ~wv[4:0]});
      wr(8'h2F, 8'($urandom));
      wr(8'h32, 8'($urandom));
      wr(8'h33, 8'($urandom));
      rdc("status ro", 8'h2F, {4'h0, ~res});
      pin(1'b0);
      check("mask cleared", msk, 8'h00);
      rdc("select a cleared", `FSWPS_OFS_SECOND_FUNC_A, 8'h00);
      check("resistor code", {3'h0, fc}, fexp(~res));
    end
    for (int l = 0; l < 3; l++) begin
      mid = (l == 0);
      low = (l == 1);
      ph = (l == 0) ? 8'h80 : 8'($urandom);
      repeat (4) @(negedge clk_sys);
      rdc("psl", 8'h32, pexp(mid, low));
      rdc("phases", 8'h33, ph);
    end
    rdc("unmapped", 8'h31, 8'h00);
    results();
  end
endmodule
